// file: core/dac_spi_map.vh
// Command codes, register map, field positions and timing counts of the DAC serial port.
`ifndef DAC_SPI_MAP_VH
`define DAC_SPI_MAP_VH

`define CMD_WRITE 2'b00
`define CMD_DISABLE 2'b01
`define CMD_ENABLE 2'b10
`define CMD_READ 2'b11

`define ADDR_DAC0 5'h00
`define ADDR_DAC1 5'h01
`define ADDR_VREF 5'h08
`define ADDR_PWRDN 5'h09
`define ADDR_STATUS 5'h0a
`define ADDR_NV_DAC0 5'h10
`define ADDR_NV_DAC1 5'h11
`define ADDR_NV_VREF 5'h18
`define ADDR_NV_PWRDN 5'h19

`define STATUS_EEPROM_WRITE_ACTIVE_BIT 6
`define STATUS_RESET 16'h0000
`define MEM_RESET 16'h0000

`define DAC_RES_BITS 12
`define DATA_UPPER_ONES 16'hf000
`define DATA_ALL_ONES 16'hffff

`define BIT_DECODE 5'd6
`define BIT_FLAG 5'd7
`define BIT_LAST 5'd23

`define CLK_PERIOD_NS 4
`define EEPROM_WRITE_CYCLE_TIME_US 4000
// One programming cycle in system clocks, 4 ms at 4 ns, sized to the timer width.
`define EEPROM_WRITE_CYCLES 21'd1000000
`define TIMER_WIDTH 21

`endif

// file: core/eeprom_write_timer.v
// Busy timer that models the length of one nonvolatile programming cycle.
`timescale 1ns/1ps
`include "dac_spi_map.vh"

module eeprom_write_timer #(
   parameter [`TIMER_WIDTH-1:0] CYCLES = `EEPROM_WRITE_CYCLES
) (
   // Clock and reset
   input wire clk,
   input wire reset,
   // Control
   input wire start,
   output reg busy
);

   localparam [`TIMER_WIDTH-1:0] TIMER_ONE = {{(`TIMER_WIDTH-1){1'b0}}, 1'b1};
   reg [`TIMER_WIDTH-1:0] count_reg;

   always @(posedge clk) begin
      if (reset) begin
         count_reg <= {`TIMER_WIDTH{1'b0}};
         busy <= 1'b0;
      end else if (start && !busy) begin
         count_reg <= CYCLES;
         busy <= 1'b1;
      end else if (busy) begin
         count_reg <= count_reg - TIMER_ONE;
         if (count_reg <= TIMER_ONE)
            busy <= 1'b0;
      end
   end

endmodule // eeprom_write_timer

// file: core/dac_spi_command_port.v
// Serial command interpreter of a dual-channel nonvolatile DAC, slave side of the SPI link.
`timescale 1ns/1ps
`include "dac_spi_map.vh"

module dac_spi_command_port #(
   parameter [`TIMER_WIDTH-1:0] EEPROM_WRITE_CYCLES = `EEPROM_WRITE_CYCLES
) (
   // Clock and reset
   input wire clk,
   input wire reset,
   // Serial link pins
   input wire cs_n,
   input wire sck,
   input wire sdi,
   output reg sdo_out,
   output reg sdo_oe_n,
   // Latch strobe and high-voltage qualifier, as logic levels
   input wire output_latch_strobe,
   input wire high_voltage_qualifier,
   // Analog side and status
   output reg [15:0] dac_value0,
   output reg [15:0] dac_value1,
   output reg [1:0] config_bits,
   output reg command_error_flag,
   output wire eeprom_write_active
);

   // Pin synchronisers: index 4 cs_n, 3 sck, 2 sdi, 1 latch strobe, 0 qualifier.
   // Two flops per pin cost about three clocks on every sck edge, so sck must stay well below clk.
   wire [4:0] pins_in;
   reg [4:0] sync1_reg;
   reg [4:0] sync2_reg;
   reg cs_n_d_reg;
   reg sck_d_reg;

   assign pins_in = {cs_n, sck, sdi, output_latch_strobe, high_voltage_qualifier};

   genvar gi;
   generate
      for (gi = 0; gi < 5; gi = gi + 1) begin : g_sync
         always @(posedge clk) begin
            if (reset) begin
               sync1_reg[gi] <= (gi == 4) ? 1'b1 : 1'b0;
               sync2_reg[gi] <= (gi == 4) ? 1'b1 : 1'b0;
            end else begin
               sync1_reg[gi] <= pins_in[gi];
               sync2_reg[gi] <= sync1_reg[gi];
            end
         end
      end
   endgenerate

   wire cs_n_s = sync2_reg[4];
   wire sck_s = sync2_reg[3];
   wire sdi_s = sync2_reg[2];
   wire latch_s = sync2_reg[1];
   // The qualifier input is already the comparator output of the elevated level.
   wire hv_s = sync2_reg[0];

   always @(posedge clk) begin
      if (reset) begin
         cs_n_d_reg <= 1'b1;
         sck_d_reg <= 1'b0;
      end else begin
         cs_n_d_reg <= cs_n_s;
         sck_d_reg <= sck_s;
      end
   end

   // The edge detectors reset to the idle pin levels, so reset release makes no false edge.
   wire cs_rise = cs_n_s && !cs_n_d_reg;
   wire sck_rise = sck_s && !sck_d_reg;
   wire sck_fall = !sck_s && sck_d_reg;

   // Frame state.
   reg [4:0] bit_cnt_reg;
   reg [15:0] shift_in_reg;
   reg [15:0] shift_out_reg;
   reg [4:0] addr_reg;
   reg [1:0] cmd_reg;
   reg err_reg;
   reg hv_ignore_reg;
   reg nv_pending_reg;
   reg [4:0] nv_addr_reg;
   reg [15:0] nv_data_reg;
   reg eeprom_start_reg;
   reg [15:0] mem [0:31];
   integer i;

   eeprom_write_timer #(
      .CYCLES(EEPROM_WRITE_CYCLES)
   ) u_timer (
      .clk(clk),
      .reset(reset),
      .start(eeprom_start_reg),
      .busy(eeprom_write_active)
   );

   function is_volatile;
      input [4:0] a;
      begin
         is_volatile = (a == `ADDR_DAC0) || (a == `ADDR_DAC1) || (a == `ADDR_VREF) ||
            (a == `ADDR_PWRDN) || (a == `ADDR_STATUS);
      end
   endfunction

   function is_nonvolatile;
      input [4:0] a;
      begin
         is_nonvolatile = (a == `ADDR_NV_DAC0) || (a == `ADDR_NV_DAC1) ||
            (a == `ADDR_NV_VREF) || (a == `ADDR_NV_PWRDN);
      end
   endfunction

   function is_dac;
      input [4:0] a;
      begin
         is_dac = (a == `ADDR_DAC0) || (a == `ADDR_DAC1) || (a == `ADDR_NV_DAC0) ||
            (a == `ADDR_NV_DAC1);
      end
   endfunction

   // Command byte decode, evaluated on the seventh rising edge.
   wire [4:0] dec_addr = shift_in_reg[5:1];
   wire [1:0] dec_cmd = {shift_in_reg[0], sdi_s};
   reg dec_ok;
   reg [15:0] rd_data;

   always @* begin
      dec_ok = 1'b0;
      case (dec_cmd)
         `CMD_READ: dec_ok = (is_volatile(dec_addr) || is_nonvolatile(dec_addr)) &&
            !(eeprom_write_active && is_nonvolatile(dec_addr));
         `CMD_WRITE: dec_ok = (is_volatile(dec_addr) || is_nonvolatile(dec_addr)) &&
            !(eeprom_write_active && is_nonvolatile(dec_addr));
         `CMD_ENABLE,
         `CMD_DISABLE: dec_ok = hv_s && !eeprom_write_active &&
            ((dec_addr == `ADDR_DAC0) || (dec_addr == `ADDR_DAC1));
         default: dec_ok = 1'b0;
      endcase
      if (nv_pending_reg)
         dec_ok = 1'b0;
   end

   // Read data is taken on the seventh rise; a later change shows only on the next read.
   always @* begin
      if (dec_addr == `ADDR_DAC0 && latch_s)
         rd_data = dac_value0;
      else if (dec_addr == `ADDR_DAC1 && latch_s)
         rd_data = dac_value1;
      else if (dec_addr == `ADDR_STATUS)
         rd_data = mem[`ADDR_STATUS];
      else
         rd_data = mem[dec_addr];
      if (dec_addr == `ADDR_STATUS)
         rd_data[`STATUS_EEPROM_WRITE_ACTIVE_BIT] = eeprom_write_active;
      if (is_dac(dec_addr))
         rd_data = rd_data | `DATA_UPPER_ONES;
   end

   // Incoming write data; DAC locations keep only the implemented low bits.
   wire [15:0] wr_word = {shift_in_reg[14:0], sdi_s};
   wire [15:0] wr_data = is_dac(addr_reg) ? (wr_word & ~`DATA_UPPER_ONES) : wr_word;

   always @(posedge clk) begin
      if (reset) begin
         bit_cnt_reg <= 5'h00;
         shift_in_reg <= 16'h0000;
         shift_out_reg <= `DATA_ALL_ONES;
         addr_reg <= 5'h00;
         cmd_reg <= `CMD_WRITE;
         err_reg <= 1'b0;
         hv_ignore_reg <= 1'b0;
         nv_pending_reg <= 1'b0;
         nv_addr_reg <= 5'h00;
         nv_data_reg <= 16'h0000;
         eeprom_start_reg <= 1'b0;
         sdo_out <= 1'b1;
         sdo_oe_n <= 1'b1;
         command_error_flag <= 1'b1;
         config_bits <= 2'b00;
         for (i = 0; i < 32; i = i + 1)
            mem[i] <= `MEM_RESET;
         mem[`ADDR_STATUS] <= `STATUS_RESET;
      end else begin
         eeprom_start_reg <= 1'b0;
         if (cs_n_s) begin
            // A frame that ended off a command boundary loses its pending nonvolatile word.
            if (cs_rise && nv_pending_reg && bit_cnt_reg == 5'h00 && !err_reg) begin
               eeprom_start_reg <= 1'b1;
               mem[nv_addr_reg] <= nv_data_reg;
            end
            bit_cnt_reg <= 5'h00;
            err_reg <= 1'b0;
            nv_pending_reg <= 1'b0;
            hv_ignore_reg <= 1'b0;
            sdo_out <= 1'b1;
            sdo_oe_n <= 1'b1;
            command_error_flag <= 1'b1;
         end else begin
            sdo_oe_n <= 1'b0;
            if (sck_rise) begin
               shift_in_reg <= wr_word;
               bit_cnt_reg <= bit_cnt_reg + 5'h01;
               if (bit_cnt_reg == `BIT_DECODE) begin
                  addr_reg <= dec_addr;
                  cmd_reg <= dec_cmd;
                  hv_ignore_reg <= hv_s && (dec_cmd == `CMD_WRITE);
                  shift_out_reg <= (dec_cmd == `CMD_READ) ? rd_data : `DATA_ALL_ONES;
                  if (!dec_ok)
                     err_reg <= 1'b1;
               end
               if (bit_cnt_reg == `BIT_FLAG &&
                     (cmd_reg == `CMD_ENABLE || cmd_reg == `CMD_DISABLE)) begin
                  bit_cnt_reg <= 5'h00;
                  if (!err_reg) begin
                     config_bits[addr_reg[0]] <= (cmd_reg == `CMD_ENABLE);
                     eeprom_start_reg <= 1'b1;
                  end
               end
               if (bit_cnt_reg == `BIT_LAST) begin
                  bit_cnt_reg <= 5'h00;
                  if (cmd_reg == `CMD_WRITE && !err_reg && !hv_ignore_reg) begin
                     // A nonvolatile word waits for chip select to rise, so a cut frame never reaches it.
                     if (is_nonvolatile(addr_reg)) begin
                        nv_pending_reg <= 1'b1;
                        nv_addr_reg <= addr_reg;
                        nv_data_reg <= wr_data;
                     end else begin
                        mem[addr_reg] <= wr_data;
                     end
                  end
               end
            end
            if (sck_fall) begin
               // The flag is driven a half clock early so the host sees it on clock eight.
               if (err_reg) begin
                  sdo_out <= 1'b0;
               end else if (bit_cnt_reg == `BIT_FLAG) begin
                  sdo_out <= 1'b1;
               end else if (bit_cnt_reg > `BIT_FLAG) begin
                  sdo_out <= shift_out_reg[15];
                  shift_out_reg <= {shift_out_reg[14:0], 1'b1};
               end
               if (bit_cnt_reg == `BIT_FLAG)
                  command_error_flag <= !err_reg;
            end
         end
      end
   end

   // Analog outputs follow the volatile registers while the latch strobe is low.
   // While it is high the outputs hold, which is why reads then show the output.
   // Each channel has its own process so that no output has two drivers.
   generate
      for (gi = 0; gi < 2; gi = gi + 1) begin : g_dac
         if (gi == 0) begin : g_ch0
            always @(posedge clk) begin
               if (reset)
                  dac_value0 <= `MEM_RESET;
               else if (!latch_s)
                  dac_value0 <= mem[`ADDR_DAC0] | `DATA_UPPER_ONES;
            end
         end else begin : g_ch1
            always @(posedge clk) begin
               if (reset)
                  dac_value1 <= `MEM_RESET;
               else if (!latch_s)
                  dac_value1 <= mem[`ADDR_DAC1] | `DATA_UPPER_ONES;
            end
         end
      end
   endgenerate

endmodule // dac_spi_command_port

// file: bench/dac_spi_monitor.sv
// Pin-level checks of the DAC serial command port.
`timescale 1ns/1ps
`include "dac_spi_map.vh"
module dac_spi_monitor #(
   parameter [`TIMER_WIDTH-1:0] EEPROM_WRITE_CYCLES = `EEPROM_WRITE_CYCLES
) (
   // Clock and reset
   input wire clk,
   input wire reset,
   // Serial link
   input wire cs_n,
   input wire sck,
   input wire sdi,
   input wire sdo_out,
   input wire sdo_oe_n,
   // Levels and status
   input wire output_latch_strobe,
   input wire high_voltage_qualifier,
   input wire [15:0] dac_value0,
   input wire [15:0] dac_value1,
   input wire [1:0] config_bits,
   input wire command_error_flag,
   input wire eeprom_write_active
);
   reg [21:0] busy_reg;
   default clocking @(posedge clk); endclocking
   default disable iff (reset);
   // The cycle length is judged only at its end, since it is far too long to unroll.
   always @(posedge clk) begin
      busy_reg <= (reset || !eeprom_write_active) ? 22'h0 : busy_reg + 22'h1;
   end
   AST_OE_IDLE: assert property (cs_n [*5] |-> sdo_oe_n && sdo_out)
      else $error("sdo not released");
   AST_OE_DRIVE: assert property (!cs_n [*6] |-> !sdo_oe_n)
      else $error("sdo not driven");
   AST_FLAG_CLEAR: assert property (cs_n [*5] |-> command_error_flag)
      else $error("error not cleared");
   AST_ERR_LOW: assert property (!command_error_flag && !sdo_oe_n |-> !sdo_out)
      else $error("sdo high after error");
   AST_SDO_ON_FALL: assert property ($changed(sdo_out) && !cs_n |-> !sck)
      else $error("sdo moved with sck high");
   AST_NV_START: assert property ($rose(eeprom_write_active) |->
      cs_n || high_voltage_qualifier) else $error("cycle started in frame");
   AST_CYCLE_LEN: assert property ($fell(eeprom_write_active) |->
      busy_reg + 2 >= EEPROM_WRITE_CYCLES && busy_reg <= EEPROM_WRITE_CYCLES + 2)
      else $error("cycle length wrong");
   AST_CFG_HV: assert property ($changed(config_bits) |-> high_voltage_qualifier)
      else $error("config changed without qualifier");
   AST_DAC_HOLD: assert property ($changed(dac_value0) |-> !output_latch_strobe)
      else $error("output moved while held");
   AST_DAC_UPPER: assert property (dac_value0 != 16'h0 |-> dac_value0[15:12] == 4'hf)
      else $error("upper bits not ones");
endmodule // dac_spi_monitor
bind dac_spi_command_port dac_spi_monitor #(.EEPROM_WRITE_CYCLES(EEPROM_WRITE_CYCLES)) u_mon (
   .clk(clk), .reset(reset), .cs_n(cs_n), .sck(sck), .sdi(sdi), .sdo_out(sdo_out),
   .sdo_oe_n(sdo_oe_n), .output_latch_strobe(output_latch_strobe),
   .high_voltage_qualifier(high_voltage_qualifier), .dac_value0(dac_value0),
   .dac_value1(dac_value1), .config_bits(config_bits),
   .command_error_flag(command_error_flag), .eeprom_write_active(eeprom_write_active));

// file: bench/spi_host_model.sv
// Host serial master model, mode 0,0, MSB first.
`timescale 1ns/1ps
module spi_host_model (
   // Clock
   input wire clk,
   // Link
   input wire sdo_out,
   input wire sdo_oe_n,
   output reg cs_n,
   output reg sck,
   output reg sdi
);
   initial begin
      cs_n = 1'b1;
      sck = 1'b0;
      sdi = 1'b0;
   end
   task xfer(input [47:0] tx, input integer n, output [47:0] rx);
      integer i;
      begin
         rx = 48'h0;
         @(negedge clk) cs_n = 1'b0;
         for (i = n - 1; i >= 0; i = i - 1) begin
            sdi = tx[i];
            repeat (10) @(negedge clk);
            sck = 1'b1;
            // An undriven line reads as unknown, so it can never pass for data.
            rx = {rx[46:0], sdo_oe_n ? 1'bx : sdo_out};
            repeat (10) @(negedge clk);
            sck = 1'b0;
         end
         repeat (10) @(negedge clk);
         cs_n = 1'b1;
         sdi = ~sdi;
         repeat (20) @(negedge clk);
      end
   endtask
endmodule // spi_host_model

// file: bench/dac_spi_command_port_tb.sv
// Self-checking bench for the DAC serial command port.
`timescale 1ns/1ps
`define CHK(a, b) begin check_count = check_count + 1; if ((a) !== (b)) begin \
   fails = fails + 1; $display("[FAIL] %0t %h %h", $time, a, b); end end
module dac_spi_command_port_tb;
   reg clk = 1'b0;
   reg reset = 1'b1;
   reg latch = 1'b0;
   reg hvq = 1'b0;
   wire cs_n, sck, sdi, sdo_out, sdo_oe_n, flag, ewa;
   wire [15:0] dac0, dac1;
   wire [1:0] cfg;
   reg [47:0] rx;
   reg [40:0] rows [0:7];
   reg [16:0] prev_rx;
   integer fails = 0, check_count = 0, cyc = 0, i, k;
   always #2 clk = ~clk;
   dac_spi_command_port #(.EEPROM_WRITE_CYCLES(21'd2000)) u_dut (
      .clk(clk), .reset(reset), .cs_n(cs_n), .sck(sck), .sdi(sdi), .sdo_out(sdo_out),
      .sdo_oe_n(sdo_oe_n), .output_latch_strobe(latch), .high_voltage_qualifier(hvq),
      .dac_value0(dac0), .dac_value1(dac1), .config_bits(cfg), .command_error_flag(flag),
      .eeprom_write_active(ewa));
   spi_host_model u_host (.clk(clk), .sdo_out(sdo_out), .sdo_oe_n(sdo_oe_n), .cs_n(cs_n),
      .sck(sck), .sdi(sdi));
   task end_of_test;
      begin
         if (fails == 0 && check_count > 0) $display("Result: passed");
         else $display("Result: failed");
         $finish;
      end
   endtask
   task wait_idle;
      for (k = 0; k < 3000 && ewa !== 1'b0; k = k + 1) @(negedge clk);
   endtask
   always @(posedge clk) begin
      cyc = cyc + 1;
      if (cyc == 40000) begin
         fails = fails + 1;
         end_of_test;
      end
   end
   initial begin
      rows[0] = {24'h000123, 17'h1ffff};
      rows[1] = {24'h060000, 17'h1f123};
      rows[2] = {24'h560000, 17'h10000};
      rows[3] = {24'h160000, 17'h00000};
      rows[4] = {24'h080abc, 17'h1ffff};
      rows[5] = {24'h0e0000, 17'h1fabc};
      rows[6] = {24'h401234, 17'h1ffff};
      rows[7] = {24'h460000, 17'h11234};
      repeat (10) @(negedge clk);
      reset = 1'b0;
      for (i = 0; i < 8; i = i + 1) begin
         u_host.xfer({24'h0, rows[i][40:17]}, 24, rx);
         `CHK(rx[16:0], rows[i][16:0])
      end
      u_host.xfer({24'h060000, 24'h0e0000}, 48, rx);
      `CHK({rx[40:24], rx[16:0]}, {17'h1f123, 17'h1fabc})
      `CHK(dac1, 16'hfabc)
      latch = 1'b1;
      u_host.xfer(48'h000777, 24, rx);
      u_host.xfer(48'h060000, 24, rx);
      `CHK(rx[16:0], 17'h1f123)
      latch = 1'b0;
      repeat (10) @(negedge clk);
      `CHK(dac0, 16'hf777)
      hvq = 1'b1;
      repeat (20) @(negedge clk);
      u_host.xfer(48'h080111, 24, rx);
      `CHK(rx[16:0], 17'h1ffff)
      u_host.xfer(48'h0e0000, 24, rx);
      `CHK(rx[16:0], 17'h1fabc)
      hvq = 1'b0;
      u_host.xfer(48'h00099, 20, rx);
      u_host.xfer(48'h060000, 24, rx);
      `CHK(rx[16:0], 17'h1f777)
      u_host.xfer({24'h800321, 24'h060000}, 48, rx);
      `CHK({rx[16:0], ewa}, 18'h0)
      u_host.xfer(48'h800321, 24, rx);
      `CHK(ewa, 1'b1)
      u_host.xfer(48'h560000, 24, rx);
      `CHK(rx[16:0], 17'h10040)
      u_host.xfer(48'h860000, 24, rx);
      `CHK(rx[16:0], 17'h0)
      u_host.xfer(48'h060000, 24, rx);
      `CHK(rx[16:0], 17'h1f777)
      wait_idle;
      u_host.xfer({24'h860000, 24'h560000}, 48, rx);
      `CHK({rx[40:24], rx[16:0]}, {17'h1f321, 17'h10000})
      u_host.xfer(48'h0c, 8, rx);
      `CHK({rx[0], cfg}, 3'b000)
      hvq = 1'b1;
      repeat (20) @(negedge clk);
      u_host.xfer(48'h04, 8, rx);
      `CHK({rx[0], cfg, ewa}, 4'b1011)
      wait_idle;
      u_host.xfer(48'h02, 8, rx);
      `CHK(cfg, 2'b00)
      hvq = 1'b0;
      // The strobe falls in mid-read; the host rereads, at most four times, until two results agree.
      latch = 1'b1;
      u_host.xfer(48'h000555, 24, rx);
      fork
         u_host.xfer(48'h060000, 24, rx);
         begin
            repeat (200) @(negedge clk);
            latch = 1'b0;
         end
      join
      prev_rx = ~rx[16:0];
      for (k = 0; k < 4 && rx[16:0] !== prev_rx; k = k + 1) begin
         prev_rx = rx[16:0];
         u_host.xfer(48'h060000, 24, rx);
      end
      `CHK(rx[16:0], 17'h1f555)
      reset = 1'b1;
      repeat (10) @(negedge clk);
      reset = 1'b0;
      `CHK({sdo_out, sdo_oe_n, flag, ewa, cfg, dac0, dac1}, {4'he, 34'h0})
      end_of_test;
   end
endmodule // dac_spi_command_port_tb
